// ### rtl/ols_top.sv
// Purpose: Step-list sequencer for one output channel setpoint
// Assumes: APB master, trigger pin asynchronous to pclk
// Notes: Lists are read back only while the sequencer is idle
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "ols_regs.svh"
module ols_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Trigger pin and routed trigger outputs
	input wire logic trig_in,
	output logic [7:0] trig_out,
	// Output stage
	output ols_pkg::ols_setpoint_t setpoint,
	output logic list_done
);
	localparam int DWELL_MAX_US = int'(`OLS_DWELL_MAX_S * 1.0e6);
	localparam int DWELL_DEF_US = int'(`OLS_DWELL_DEF_S * 1.0e6);
	localparam int TICK_CYC = `OLS_TICK_CYC;

	ols_pkg::ols_state_t state;
	logic [9:0] lens [`OLS_LISTS];
	logic [27:0] rdat [`OLS_LISTS];
	logic [27:0] wdat [`OLS_LISTS];
	logic [8:0] raddr [`OLS_LISTS];
	logic [`OLS_LISTS-1:0] we;
	logic [1:0] qty;
	logic trig_pace, keep_last, done_f, err_f, hold;
	logic [15:0] repeat_cnt, rep_left, base, sp_value;
	logic [8:0] host_idx, step;
	logic [7:0] route;
	logic [511:0] dw_set;
	logic dw_set_q, cur_fe, start_p, end_p;
	logic [27:0] dw_val, dw_left, dw_wr;
	logic [6:0] tick_cnt;
	logic tick;
	logic s1, s2, s3, lvl, pin_edge;
	logic wr, ctrl_wr, arm_p, abort_p, trig_acc, idle, mapped;
	logic [9:0] n_max;
	logic lens_ok, last, adv;
	logic [31:0] rd_mux;

	// APB decode, zero wait states
	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign idle = (state == ols_pkg::OLS_IDLE) || (state == ols_pkg::OLS_ARMED);
	assign ctrl_wr = wr && (paddr == `OLS_A_CTRL);
	assign arm_p = ctrl_wr & pwdata[`OLS_C_ARM];
	assign abort_p = ctrl_wr & pwdata[`OLS_C_ABORT];

	always_comb begin
		case (paddr)
			`OLS_A_CTRL, `OLS_A_STATUS, `OLS_A_REPEAT, `OLS_A_LEN_SP, `OLS_A_LEN_DW,
			`OLS_A_LEN_FS, `OLS_A_LEN_FE, `OLS_A_INDEX, `OLS_A_SP_DATA,
			`OLS_A_DW_DATA, `OLS_A_FLAGS, `OLS_A_BASE, `OLS_A_ROUTE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~mapped;

	// Configuration registers; writes while running are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qty <= 2'h0;
			trig_pace <= 1'b0;
			keep_last <= 1'b0;
			repeat_cnt <= `OLS_RST_REPEAT;
			host_idx <= 9'h000;
			base <= `OLS_RST_BASE;
			route <= `OLS_RST_ROUTE;
		end else if (wr && idle) begin
			case (paddr)
				`OLS_A_CTRL: begin
					qty <= pwdata[`OLS_C_QTY];
					trig_pace <= pwdata[`OLS_C_TRIG_PACE];
					keep_last <= pwdata[`OLS_C_KEEP_LAST];
				end
				`OLS_A_REPEAT: repeat_cnt <= pwdata[15:0];
				`OLS_A_INDEX: host_idx <= pwdata[8:0];
				`OLS_A_BASE: base <= pwdata[15:0];
				`OLS_A_ROUTE: route <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Dwell writes clamp to the documented span
	assign dw_wr = (pwdata > 32'(DWELL_MAX_US)) ? 28'(DWELL_MAX_US) : pwdata[27:0];
	assign wdat[0] = {12'h000, pwdata[15:0]};
	assign wdat[1] = dw_wr;
	assign wdat[2] = {27'h0000000, pwdata[`OLS_F_START]};
	assign wdat[3] = {27'h0000000, pwdata[`OLS_F_END]};
	assign we[0] = wr && idle && (paddr == `OLS_A_SP_DATA);
	assign we[1] = wr && idle && (paddr == `OLS_A_DW_DATA);
	assign we[2] = wr && idle && (paddr == `OLS_A_FLAGS);
	assign we[3] = we[2];

	// One memory and one length per list
	genvar gi;
	generate
		for (gi = 0; gi < `OLS_LISTS; gi++) begin : g_list
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					lens[gi] <= `OLS_RST_LEN;
				end else if (wr && idle && (paddr == 8'(`OLS_A_LEN_SP + 4 * gi))) begin
					lens[gi] <= (pwdata > 32'(`OLS_LEN_MAX)) ? `OLS_LEN_MAX : pwdata[9:0];
				end
			end
			// Single entry lists read entry zero while running
			assign raddr[gi] = idle ? host_idx : ((lens[gi] == `OLS_LEN_ONE) ? 9'h000 : step);
			ols_mem #(.W(28)) u_mem (
				.pclk(pclk),
				.we(we[gi]),
				.waddr(host_idx),
				.wdata(wdat[gi]),
				.raddr(raddr[gi]),
				.rdata(rdat[gi])
			);
		end
	endgenerate

	// Written-entry map stands in for clearing the dwell RAM at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dw_set <= '0;
		end else if (we[1]) begin
			dw_set[host_idx] <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dw_set_q <= 1'b0;
		end else begin
			dw_set_q <= dw_set[raddr[1]];
		end
	end
	assign dw_val = dw_set_q ? rdat[1] : 28'(DWELL_DEF_US);

	// Length check: every list has the longest length or one entry
	always_comb begin
		n_max = 10'h000;
		lens_ok = 1'b1;
		for (int i = 0; i < `OLS_LISTS; i++) begin
			if (lens[i] > n_max) begin
				n_max = lens[i];
			end
		end
		for (int i = 0; i < `OLS_LISTS; i++) begin
			if (lens[i] != n_max && lens[i] != `OLS_LEN_ONE) begin
				lens_ok = 1'b0;
			end
		end
		if (n_max == 10'h000) begin
			lens_ok = 1'b0;
		end
	end

	// Trigger pin: three flops, change accepted once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			lvl <= 1'b0;
		end else begin
			s1 <= trig_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				lvl <= s3;
			end
		end
	end
	assign pin_edge = (s2 == s3) & s3 & ~lvl;
	assign trig_acc = pin_edge | (ctrl_wr & pwdata[`OLS_C_SW_TRIG]);

	// Microsecond tick, restarted on each step load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 7'h00;
		end else if (state != ols_pkg::OLS_DWELL || tick) begin
			tick_cnt <= 7'h00;
		end else begin
			tick_cnt <= tick_cnt + 7'h01;
		end
	end
	assign tick = (tick_cnt == 7'(TICK_CYC - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dw_left <= 28'h0000000;
		end else if (state == ols_pkg::OLS_LOAD) begin
			dw_left <= dw_val;
		end else if (state == ols_pkg::OLS_DWELL && tick && dw_left != 28'h0000000) begin
			dw_left <= dw_left - 28'h0000001;
		end
	end

	// Step end: dwell expiry in auto pacing, accepted trigger otherwise
	assign last = ({1'b0, step} == n_max - `OLS_LEN_ONE);
	always_comb begin
		adv = 1'b0;
		if (state == ols_pkg::OLS_DWELL && dw_left == 28'h0000000 && !trig_pace) begin
			adv = 1'b1;
		end
		if (state == ols_pkg::OLS_WAIT && trig_acc) begin
			adv = 1'b1;
		end
	end

	// Sequencer; triggers in OLS_DWELL are never looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ols_pkg::OLS_IDLE;
			step <= 9'h000;
			rep_left <= 16'h0000;
		end else if (abort_p) begin
			state <= ols_pkg::OLS_IDLE;
		end else begin
			case (state)
				ols_pkg::OLS_IDLE: begin
					if (arm_p) begin
						state <= ols_pkg::OLS_ARMED;
					end
				end
				ols_pkg::OLS_ARMED: begin
					if (trig_acc) begin
						state <= lens_ok ? ols_pkg::OLS_FETCH : ols_pkg::OLS_IDLE;
						step <= 9'h000;
						rep_left <= (repeat_cnt == 16'h0000) ? 16'h0001 : repeat_cnt;
					end
				end
				ols_pkg::OLS_FETCH: state <= ols_pkg::OLS_LOAD;
				ols_pkg::OLS_LOAD: state <= ols_pkg::OLS_DWELL;
				ols_pkg::OLS_DWELL: begin
					if (dw_left == 28'h0000000 && trig_pace) begin
						state <= ols_pkg::OLS_WAIT;
					end
				end
				ols_pkg::OLS_WAIT: ;
				default: state <= ols_pkg::OLS_IDLE;
			endcase
			if (adv) begin
				if (!last) begin
					step <= step + 9'h001;
					state <= ols_pkg::OLS_FETCH;
				end else if (rep_left > 16'h0001) begin
					step <= 9'h000;
					rep_left <= rep_left - 16'h0001;
					state <= ols_pkg::OLS_FETCH;
				end else begin
					state <= ols_pkg::OLS_IDLE;
				end
			end
		end
	end

	// Status flags: a new arm clears them; the run's own event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_f <= 1'b0;
			err_f <= 1'b0;
		end else begin
			if (state == ols_pkg::OLS_ARMED && trig_acc && !lens_ok) begin
				err_f <= 1'b1;
			end else if (arm_p && state == ols_pkg::OLS_IDLE) begin
				err_f <= 1'b0;
			end
			if (adv && last && rep_left <= 16'h0001) begin
				done_f <= 1'b1;
			end else if (arm_p && state == ols_pkg::OLS_IDLE) begin
				done_f <= 1'b0;
			end
		end
	end

	// Setpoint and step trigger pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_value <= `OLS_RST_BASE;
			hold <= 1'b0;
			cur_fe <= 1'b0;
			start_p <= 1'b0;
			end_p <= 1'b0;
			list_done <= 1'b0;
		end else begin
			start_p <= 1'b0;
			end_p <= 1'b0;
			list_done <= 1'b0;
			if (state == ols_pkg::OLS_LOAD) begin
				sp_value <= rdat[0][15:0];
				cur_fe <= rdat[3][0];
				start_p <= rdat[2][0];
			end else if (adv) begin
				end_p <= cur_fe;
				if (last && rep_left <= 16'h0001) begin
					list_done <= 1'b1;
					hold <= keep_last;
					sp_value <= keep_last ? sp_value : base;
				end
			end else if (idle && !hold) begin
				sp_value <= base;
			end
			if (arm_p || abort_p) begin
				hold <= 1'b0;
			end
		end
	end

	// Routed copies of the step triggers; a set route bit enables an output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_out <= 8'h00;
		end else begin
			trig_out <= {8{start_p | end_p}} & route;
		end
	end

	assign setpoint.kind = qty;
	assign setpoint.active = ~idle;
	assign setpoint.value = sp_value;

	// Read mux; list data reflect host_idx only while idle
	always_comb begin
		rd_mux = 32'h00000000;
		case (paddr)
			`OLS_A_CTRL: rd_mux = {28'h0000000, keep_last, trig_pace, qty};
			`OLS_A_STATUS: begin
				rd_mux[`OLS_S_RUN] = ~idle;
				rd_mux[`OLS_S_DONE] = done_f;
				rd_mux[`OLS_S_ERR] = err_f;
				rd_mux[`OLS_S_ARMED] = (state == ols_pkg::OLS_ARMED);
				rd_mux[`OLS_S_STEP] = step;
			end
			`OLS_A_REPEAT: rd_mux = {16'h0000, repeat_cnt};
			`OLS_A_LEN_SP: rd_mux = {22'h000000, lens[0]};
			`OLS_A_LEN_DW: rd_mux = {22'h000000, lens[1]};
			`OLS_A_LEN_FS: rd_mux = {22'h000000, lens[2]};
			`OLS_A_LEN_FE: rd_mux = {22'h000000, lens[3]};
			`OLS_A_INDEX: rd_mux = {23'h000000, host_idx};
			`OLS_A_SP_DATA: rd_mux = {16'h0000, rdat[0][15:0]};
			`OLS_A_DW_DATA: rd_mux = {4'h0, dw_val};
			`OLS_A_FLAGS: rd_mux = {30'h00000000, rdat[3][0], rdat[2][0]};
			`OLS_A_BASE: rd_mux = {16'h0000, base};
			`OLS_A_ROUTE: rd_mux = {24'h000000, route};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Captured in the setup cycle so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_step_bound;
		!idle |-> ({1'b0, step} < n_max);
	endproperty
	a_step_bound: assert property (p_step_bound) else $error("step beyond list length");

	property p_start_zero;
		state == ols_pkg::OLS_ARMED && trig_acc && lens_ok && !abort_p
			|=> state == ols_pkg::OLS_FETCH && step == 9'h000;
	endproperty
	a_start_zero: assert property (p_start_zero) else $error("run did not start at step 0");

	property p_len_err;
		state == ols_pkg::OLS_ARMED && trig_acc && !lens_ok
			|=> state == ols_pkg::OLS_IDLE && err_f;
	endproperty
	a_len_err: assert property (p_len_err) else $error("length mismatch not refused");

	property p_discard;
		state == ols_pkg::OLS_DWELL && dw_left != 28'h0000000 && trig_acc && !abort_p
			|=> $stable(step) && state == ols_pkg::OLS_DWELL;
	endproperty
	a_discard: assert property (p_discard) else $error("trigger advanced during dwell");

	property p_auto;
		state == ols_pkg::OLS_DWELL && dw_left == 28'h0000000 && !trig_pace && !abort_p
			|=> state == ols_pkg::OLS_FETCH || state == ols_pkg::OLS_IDLE;
	endproperty
	a_auto: assert property (p_auto) else $error("auto pacing did not advance");

	property p_trig_step;
		state == ols_pkg::OLS_WAIT && trig_acc && !last && !abort_p
			|=> step == $past(step) + 9'h001 ##2 state == ols_pkg::OLS_DWELL;
	endproperty
	a_trig_step: assert property (p_trig_step) else $error("trigger did not advance one step");

	property p_repeat;
		adv && last && rep_left > 16'h0001 && !abort_p
			|=> step == 9'h000 && rep_left == $past(rep_left) - 16'h0001;
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat did not restart list");

	property p_start_trig;
		state == ols_pkg::OLS_LOAD && rdat[2][0] && route != 8'h00
			|=> start_p ##1 trig_out == route;
	endproperty
	a_start_trig: assert property (p_start_trig) else $error("start trigger missing");

	property p_terminate;
		list_done && !hold |-> sp_value == base;
	endproperty
	a_terminate: assert property (p_terminate) else $error("setpoint not returned to base");

	property p_dwell_def;
		state == ols_pkg::OLS_LOAD && !dw_set_q |=> dw_left == 28'(DWELL_DEF_US);
	endproperty
	a_dwell_def: assert property (p_dwell_def) else $error("default dwell not used");
endmodule

// ### rtl/ols_regs.svh
// Purpose: Register map, field positions, reset values and timing constants
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Definitions only
`ifndef OLS_REGS_SVH
`define OLS_REGS_SVH

// Register byte offsets
`define OLS_A_CTRL 8'h00
`define OLS_A_STATUS 8'h04
`define OLS_A_REPEAT 8'h08
`define OLS_A_LEN_SP 8'h0C
`define OLS_A_LEN_DW 8'h10
`define OLS_A_LEN_FS 8'h14
`define OLS_A_LEN_FE 8'h18
`define OLS_A_INDEX 8'h1C
`define OLS_A_SP_DATA 8'h20
`define OLS_A_DW_DATA 8'h24
`define OLS_A_FLAGS 8'h28
`define OLS_A_BASE 8'h2C
`define OLS_A_ROUTE 8'h30

// Control fields
`define OLS_C_QTY 1:0
`define OLS_C_TRIG_PACE 2
`define OLS_C_KEEP_LAST 3
`define OLS_C_ARM 4
`define OLS_C_ABORT 5
`define OLS_C_SW_TRIG 6

// Status fields
`define OLS_S_RUN 0
`define OLS_S_DONE 1
`define OLS_S_ERR 2
`define OLS_S_ARMED 3
`define OLS_S_STEP 24:16

// Flag fields
`define OLS_F_START 0
`define OLS_F_END 1

// Sizes
`define OLS_DEPTH 512
`define OLS_LEN_MAX 10'h200
`define OLS_LEN_ONE 10'h001
`define OLS_LISTS 4

// Reset values
`define OLS_RST_REPEAT 16'h0001
`define OLS_RST_LEN 10'h000
`define OLS_RST_BASE 16'h0000
`define OLS_RST_ROUTE 8'h00

// Timing
`define OLS_CLK_MHZ 100
`define OLS_TICK_US 1
`define OLS_TICK_CYC (`OLS_TICK_US * `OLS_CLK_MHZ)
`define OLS_DWELL_MAX_S 262.144
`define OLS_DWELL_DEF_S 0.001

`endif

// ### rtl/ols_pkg.sv
// Purpose: Types shared by the list sequencer files
// Assumes: Constants live in ols_regs.svh
// Notes: None
package ols_pkg;
	typedef enum logic [2:0] {
		OLS_IDLE,
		OLS_ARMED,
		OLS_FETCH,
		OLS_LOAD,
		OLS_DWELL,
		OLS_WAIT
	} ols_state_t;

	typedef struct packed {
		logic [1:0] kind;
		logic active;
		logic [15:0] value;
	} ols_setpoint_t;
endpackage

// ### rtl/ols_mem.sv
// Purpose: One list of step entries, synchronous write, registered read
// Assumes: Single clock
// Notes: Contents are volatile and not reset
`timescale 1ns/1ps
`include "ols_regs.svh"
module ols_mem #(
	parameter int W = 28
) (
	// Clock
	input wire logic pclk,
	// Write port
	input wire logic we,
	input wire logic [8:0] waddr,
	input wire logic [W-1:0] wdata,
	// Read port
	input wire logic [8:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [0:`OLS_DEPTH-1];

	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge pclk) begin
		rdata <= mem[raddr];
	end
endmodule

// ### dv/ols_stage_model.sv
// Purpose: Output stage stand-in that logs step values and trigger pulses
// Assumes: Routed trigger bit 0 carries the step pulse
// Notes: Drives the external trigger pin when the bench asks
`timescale 1ns/1ps
module ols_stage_model (
	// Clock
	input wire logic pclk,
	// From the sequencer
	input wire ols_pkg::ols_setpoint_t setpoint,
	input wire logic [7:0] trig_out,
	input wire logic list_done,
	// Trigger pin
	output logic trig_in
);
	logic [15:0] seen[$];
	int stamp[$];
	int cyc;
	int n_done;
	logic [7:0] pat;

	initial begin
		trig_in = 1'b0;
		cyc = 0;
		n_done = 0;
		pat = 8'h00;
	end

	// Held three edges so the input synchroniser cannot miss it
	task automatic fire();
		@(posedge pclk);
		trig_in <= 1'b1;
		repeat (3) @(posedge pclk);
		trig_in <= 1'b0;
	endtask

	task automatic clear();
		seen.delete();
		stamp.delete();
		n_done = 0;
		pat = 8'h00;
	endtask

	// Value logged at the pulse, since the pulse trails the new value by one cycle
	always @(posedge pclk) begin
		cyc++;
		if (trig_out[0] === 1'b1) begin
			seen.push_back(setpoint.value);
			stamp.push_back(cyc);
		end
		if (list_done === 1'b1) begin
			n_done++;
		end
		// Last non-idle pattern on the routed outputs
		if (trig_out !== 8'h00) begin
			pat = trig_out;
		end
	end
endmodule

// ### dv/tb.sv
// Purpose: Self-checking bench for the list sequencer
// Assumes: Zero-wait APB slave, trigger pin driven by the stage model
// Notes: Dwell entries in microseconds, 100 cycles each
`timescale 1ns/1ps
`include "ols_regs.svh"
module tb;
	// Clock, reset and bus
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err_seen;
	// Sequencer side
	logic trig_in, list_done;
	logic [7:0] trig_out;
	ols_pkg::ols_setpoint_t setpoint;
	int n_mismatch, n_compared;

	ols_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trig_in(trig_in), .trig_out(trig_out),
		.setpoint(setpoint), .list_done(list_done));
	ols_stage_model u_stage (.pclk(pclk), .setpoint(setpoint), .trig_out(trig_out),
		.list_done(list_done), .trig_in(trig_in));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic put(input logic [8:0] i, input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, `OLS_A_INDEX, {23'h0, i});
		xfer(1'b1, a, d);
	endtask

	task automatic lens(input logic [9:0] s, input logic [9:0] w, input logic [9:0] f);
		xfer(1'b1, `OLS_A_LEN_SP, {22'h0, s});
		xfer(1'b1, `OLS_A_LEN_DW, {22'h0, w});
		xfer(1'b1, `OLS_A_LEN_FS, {22'h0, f});
		xfer(1'b1, `OLS_A_LEN_FE, {22'h0, f});
	endtask

	task automatic wait_done(input int lim);
		int k;
		k = 0;
		while (u_stage.n_done == 0 && k < lim) begin
			@(posedge pclk);
			k++;
		end
		chk(32'h1, u_stage.n_done);
	endtask

	task automatic t_regs();
		xfer(1'b0, `OLS_A_REPEAT, 32'h0);
		chk(32'h1, rd);
		put(9'h007, `OLS_A_SP_DATA, 32'h0);
		xfer(1'b0, `OLS_A_DW_DATA, 32'h0);
		chk(32'h3E8, rd);
		xfer(1'b0, 8'h34, 32'h0);
		chk(32'h1, err_seen);
		chk(32'h0, rd);
		put(9'h1FF, `OLS_A_SP_DATA, 32'hA5C3);
		xfer(1'b0, `OLS_A_SP_DATA, 32'h0);
		chk(32'hA5C3, rd);
		put(9'h1FF, `OLS_A_DW_DATA, 32'h0FFFFFFF);
		xfer(1'b0, `OLS_A_DW_DATA, 32'h0);
		chk(32'h0FA00000, rd);
		for (int q = 0; q < 4; q++) begin
			xfer(1'b1, `OLS_A_CTRL, q);
			@(posedge pclk);
			chk(q, setpoint.kind);
		end
		$display("test regs done");
	endtask

	task automatic t_auto();
		logic [15:0] exp [4] = '{16'h1111, 16'h2222, 16'h1111, 16'h2222};
		int g;
		put(9'h000, `OLS_A_SP_DATA, 32'h1111);
		xfer(1'b1, `OLS_A_DW_DATA, 32'h0);
		xfer(1'b1, `OLS_A_FLAGS, 32'h1);
		put(9'h001, `OLS_A_SP_DATA, 32'h2222);
		xfer(1'b1, `OLS_A_DW_DATA, 32'h1);
		xfer(1'b1, `OLS_A_FLAGS, 32'h1);
		lens(10'h2, 10'h2, 10'h2);
		xfer(1'b1, `OLS_A_REPEAT, 32'h2);
		xfer(1'b1, `OLS_A_BASE, 32'h0055);
		xfer(1'b1, `OLS_A_ROUTE, 32'h01);
		u_stage.clear();
		xfer(1'b1, `OLS_A_CTRL, 32'h11);
		xfer(1'b0, `OLS_A_STATUS, 32'h0);
		chk(32'h8, rd & 32'hF);
		xfer(1'b1, `OLS_A_CTRL, 32'h41);
		wait_done(2000);
		chk(32'h4, u_stage.seen.size());
		for (int i = 0; i < u_stage.seen.size() && i < 4; i++) begin
			chk(exp[i], u_stage.seen[i]);
		end
		if (u_stage.stamp.size() > 2) begin
			g = u_stage.stamp[1] - u_stage.stamp[0];
			chk(32'h1, g >= 3 && g <= 4);
			g = u_stage.stamp[2] - u_stage.stamp[1];
			chk(32'h1, g >= 100 && g <= 106);
		end
		repeat (3) @(posedge pclk);
		chk(32'h0055, setpoint.value);
		chk(32'h0, setpoint.active);
		xfer(1'b0, `OLS_A_STATUS, 32'h0);
		chk(32'h2, rd & 32'hF);
		$display("test auto done");
	endtask

	task automatic t_pace();
		put(9'h000, `OLS_A_SP_DATA, 32'h0A01);
		xfer(1'b1, `OLS_A_DW_DATA, 32'h2);
		xfer(1'b1, `OLS_A_FLAGS, 32'h1);
		put(9'h001, `OLS_A_SP_DATA, 32'h0A02);
		put(9'h002, `OLS_A_SP_DATA, 32'h0A03);
		lens(10'h3, 10'h1, 10'h1);
		xfer(1'b1, `OLS_A_REPEAT, 32'h1);
		u_stage.clear();
		xfer(1'b1, `OLS_A_CTRL, 32'h1C);
		u_stage.fire();
		repeat (20) @(posedge pclk);
		chk(32'h1, setpoint.active);
		// Second trigger lands while the 200-cycle dwell still runs
		u_stage.fire();
		repeat (30) @(posedge pclk);
		chk(32'h1, u_stage.seen.size());
		for (int n = 2; n <= 4; n++) begin
			repeat (250) @(posedge pclk);
			u_stage.fire();
			repeat (20) @(posedge pclk);
			chk((n < 4) ? n : 3, u_stage.seen.size());
		end
		wait_done(100);
		chk(32'h0A03, setpoint.value);
		if (u_stage.seen.size() == 3) begin
			chk(32'h0A02, u_stage.seen[1]);
		end
		$display("test pace done");
	endtask

	task automatic t_mismatch();
		lens(10'h2, 10'h3, 10'h2);
		u_stage.clear();
		xfer(1'b1, `OLS_A_CTRL, 32'h10);
		xfer(1'b1, `OLS_A_CTRL, 32'h40);
		repeat (10) @(posedge pclk);
		xfer(1'b0, `OLS_A_STATUS, 32'h0);
		chk(32'h4, rd & 32'hF);
		chk(32'h0, setpoint.active);
		chk(32'h0, u_stage.seen.size());
		$display("test mismatch done");
	endtask

	task automatic t_defdwell();
		put(9'h000, `OLS_A_FLAGS, 32'h3);
		lens(10'h1, 10'h3, 10'h1);
		xfer(1'b1, `OLS_A_ROUTE, 32'h81);
		u_stage.clear();
		xfer(1'b1, `OLS_A_CTRL, 32'h10);
		xfer(1'b1, `OLS_A_CTRL, 32'h40);
		// Step 2 dwell was never written, so it must sit on the long default
		repeat (350) @(posedge pclk);
		xfer(1'b0, `OLS_A_STATUS, 32'h0);
		chk(32'h00020001, rd);
		chk(32'h0A01, setpoint.value);
		chk(32'h5, u_stage.seen.size());
		chk(32'h81, u_stage.pat);
		xfer(1'b1, `OLS_A_CTRL, 32'h20);
		repeat (2) @(posedge pclk);
		chk(32'h0, setpoint.active);
		chk(32'h0055, setpoint.value);
		$display("test default dwell done");
	endtask

	task automatic report_and_stop();
		$display("compared=%0d mismatched=%0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Whole run needs under two thousand cycles; this leaves wide margin
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_auto();
		t_pace();
		t_mismatch();
		t_defdwell();
		report_and_stop();
	end
endmodule
